/* File: design/line_word_window.sv */
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "window_defs.svh"
module line_word_window (
  input  wire logic         clk,              // System clock, 250 MHz
  input  wire logic         rst_b,            // Synchronous reset
  input  wire logic [7:0]   reg_addr,         // Register byte address
  input  wire logic [31:0]  reg_wdata,        // Register write data
  input  wire logic         reg_write,        // Write strobe
  input  wire logic         reg_read,         // Read strobe
  output logic      [31:0]  reg_rdata,        // Read data, cycle after the strobe
  input  wire logic         cam_fval,         // Camera frame valid pin
  input  wire logic         cam_lval,         // Camera line valid pin
  input  wire logic         cam_word_valid,   // Camera 16-byte word strobe pin
  input  wire logic [127:0] cam_word,         // Camera 16-byte data word
  input  wire logic         trig_in,          // Selected trigger source pin
  input  wire logic         enc_a_in,         // Selected encoder phase A pin
  input  wire logic         enc_b_in,         // Selected encoder phase B pin
  input  wire logic         enc_div_in,       // Selected encoder divider pin
  input  wire logic         enc_quad_in,      // Selected encoder quadrature pin
  input  wire logic         acq_enable,       // Frames remain to be acquired
  input  wire logic         acq_start,        // Acquisition start pulse
  input  wire logic         volume_start,     // Volume window start pulse
  input  wire logic         volume_end,       // Volume window end pulse
  input  wire logic         sequence_start,   // Frame sequence window start pulse
  input  wire logic         sequence_end,     // Frame sequence window end pulse
  output logic              line_window_open, // Line window is open
  output logic              word_window_open, // Word window is open
  output logic              word_out_valid,   // Acquired word strobe
  output logic      [127:0] word_out,         // Acquired word
  output logic              line_done,        // Acquired line finished pulse
  output logic              frame_done        // Line window closed pulse
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [135:0] pins_sync;
  logic         fval_s;
  logic         lval_s;
  logic         wv_s;
  logic [4:0]   trig_s;
  logic [127:0] word_s;

  sync_bits #(
    .WIDTH    (136)
  ) u_pins (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({cam_fval, cam_lval, cam_word_valid, enc_quad_in, enc_div_in,
                enc_b_in, enc_a_in, trig_in, cam_word}),
    .sync_out (pins_sync)
  );

  assign fval_s = pins_sync[135];
  assign lval_s = pins_sync[134];
  assign wv_s   = pins_sync[133];
  assign trig_s = pins_sync[132:128];
  assign word_s = pins_sync[127:0];

  logic lval_q;
  logic lval_rise;
  logic lval_fall;

  assign lval_rise = lval_s & ~lval_q;
  assign lval_fall = ~lval_s & lval_q;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0] line_window_control;
  logic [31:0] line_window_dimensions;
  logic [31:0] line_window_dimensions_upper;
  logic [31:0] word_window_dimensions;
  logic [31:0] word_window_dimensions_upper;
  logic [23:0] volumes_acquired;
  logic [23:0] volume_running;
  logic [1:0]  volume_count_clear_mode;
  logic [1:0]  volume_count_update_mode;

  logic wr_ctrl;
  logic wr_ldim;
  logic wr_lup;
  logic wr_wdim;
  logic wr_wup;
  logic wr_vol;

  assign wr_ctrl = reg_write & (reg_addr == `OFS_LINE_CONTROL);
  assign wr_ldim = reg_write & (reg_addr == `OFS_LINE_DIMS);
  assign wr_lup  = reg_write & (reg_addr == `OFS_LINE_DIMS_UPPER);
  assign wr_wdim = reg_write & (reg_addr == `OFS_WORD_DIMS);
  assign wr_wup  = reg_write & (reg_addr == `OFS_WORD_DIMS_UPPER);
  assign wr_vol  = reg_write & (reg_addr == `OFS_VOLUME_COUNT);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      line_window_control          <= `RST_LINE_CONTROL;
      line_window_dimensions       <= `RST_DIMS;
      line_window_dimensions_upper <= `RST_DIMS;
      word_window_dimensions       <= `RST_DIMS;
      word_window_dimensions_upper <= `RST_DIMS;
      volume_count_clear_mode      <= 2'h0;
      volume_count_update_mode     <= 2'h0;
    end else begin
      if (wr_ctrl) line_window_control <= reg_wdata & `MASK_LINE_CONTROL;
      if (wr_ldim) line_window_dimensions <= reg_wdata;
      if (wr_lup) line_window_dimensions_upper <= reg_wdata & `MASK_DIMS_UPPER;
      if (wr_wdim) word_window_dimensions <= reg_wdata;
      if (wr_wup) word_window_dimensions_upper <= reg_wdata & `MASK_DIMS_UPPER;
      if (wr_vol) begin
        volume_count_clear_mode  <= reg_wdata[`LSB_VOL_CLR_MODE +: 2];
        volume_count_update_mode <= reg_wdata[`LSB_VOL_UPD_MODE +: 2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  // Base field below, extension byte above it
  function automatic logic [23:0] widen(input logic [15:0] base, input logic [7:0] upper);
    widen = {upper, base};
  endfunction

  logic [3:0]  line_close_condition;
  logic [3:0]  line_close_source;
  logic [3:0]  line_close_mode;
  logic [3:0]  line_open_condition;
  logic [3:0]  line_open_source;
  logic        line_open_on_trigger;
  logic        line_sync_on;
  logic [23:0] lines_to_take;
  logic [23:0] lines_to_skip;
  logic [23:0] words_to_take;
  logic [23:0] words_to_skip;

  assign line_close_condition = line_window_control[`LSB_CLOSE_COND +: 4];
  assign line_close_source    = line_window_control[`LSB_CLOSE_SRC +: 4];
  assign line_close_mode      = line_window_control[`LSB_CLOSE_MODE +: 4];
  assign line_open_condition  = line_window_control[`LSB_OPEN_COND +: 4];
  assign line_open_source     = line_window_control[`LSB_OPEN_SRC +: 4];
  // Any nonzero open mode is taken as trigger mode
  assign line_open_on_trigger = |line_window_control[`LSB_OPEN_MODE +: 4];
  // Only code 1 enforces start of line; other codes behave as no sync
  assign line_sync_on = (line_window_control[`LSB_LINE_SYNC +: 4] == 4'h1);

  assign lines_to_take = widen(line_window_dimensions[`LSB_SIZE +: 16],
                               line_window_dimensions_upper[`LSB_SIZE +: 8]);
  assign lines_to_skip = widen(line_window_dimensions[`LSB_SKIP +: 16],
                               line_window_dimensions_upper[`LSB_SKIP +: 8]);
  assign words_to_take = widen(word_window_dimensions[`LSB_SIZE +: 16],
                               word_window_dimensions_upper[`LSB_SIZE +: 8]);
  assign words_to_skip = widen(word_window_dimensions[`LSB_SKIP +: 16],
                               word_window_dimensions_upper[`LSB_SKIP +: 8]);

  // ----------------------------------------------------------------------
  // Trigger conditioning
  // ----------------------------------------------------------------------
  logic open_hit;
  logic close_hit;

  trigger_condition u_open_trig (
    .clk     (clk),
    .rst_b   (rst_b),
    .sources ({fval_s, trig_s}),
    .source  (line_open_source),
    .cond    (line_open_condition),
    .hit     (open_hit)
  );

  trigger_condition u_close_trig (
    .clk     (clk),
    .rst_b   (rst_b),
    .sources ({fval_s, trig_s}),
    .source  (line_close_source),
    .cond    (line_close_condition),
    .hit     (close_hit)
  );

  // ----------------------------------------------------------------------
  // Line window sequencing
  // ----------------------------------------------------------------------
  window_pkg::state_t state;
  window_pkg::state_t next_state;

  logic        in_line;
  logic        close_pending;
  logic [23:0] line_index;
  logic [23:0] lines_got;
  logic [23:0] word_index;

  logic open_ready;
  logic opening;
  logic live;
  logic line_active;
  logic line_wanted;
  logic line_end;
  logic size_reached;
  logic trig_close;
  logic closing;
  logic word_in_range;
  logic word_take;

  // Immediate open still waits for a start of line when line sync is on
  assign open_ready = line_open_on_trigger ? open_hit
                                           : (!line_sync_on | lval_rise);
  assign opening    = (state == window_pkg::ST_WAIT_OPEN) & acq_enable & open_ready;
  // Opening is live in the same cycle so a word beside the start of line is kept
  assign live       = (state == window_pkg::ST_OPEN) | opening;

  assign line_active = line_sync_on ? (in_line | lval_rise) : 1'b1;
  assign line_wanted = (line_index >= lines_to_skip);
  assign line_end    = (state == window_pkg::ST_OPEN) & lval_fall & (in_line | !line_sync_on);

  assign size_reached = line_end & line_wanted &
                        ((lines_got + 24'h000001) >= lines_to_take);
  // A close trigger between lines closes at once: that gap is the boundary
  assign trig_close   = (close_hit | close_pending) & (line_end | !lval_s);

  always_comb begin
    closing = 1'b0;
    if (state == window_pkg::ST_OPEN) begin
      case (line_close_mode)
        window_pkg::CLOSE_SIZE:    closing = size_reached;
        window_pkg::CLOSE_TRIGGER: closing = trig_close;
        window_pkg::CLOSE_EITHER:  closing = size_reached | trig_close;
        default:                   closing = size_reached;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      window_pkg::ST_IDLE: begin
        if (acq_enable) next_state = window_pkg::ST_WAIT_OPEN;
      end
      window_pkg::ST_WAIT_OPEN: begin
        if (!acq_enable) next_state = window_pkg::ST_IDLE;
        else if (opening) next_state = window_pkg::ST_OPEN;
      end
      window_pkg::ST_OPEN: begin
        // After a close, rearm only while more frames are wanted
        if (closing) begin
          next_state = acq_enable ? window_pkg::ST_WAIT_OPEN : window_pkg::ST_IDLE;
        end
      end
      default: next_state = window_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state         <= window_pkg::ST_IDLE;
      lval_q        <= 1'b0;
      in_line       <= 1'b0;
      close_pending <= 1'b0;
      line_index    <= 24'h000000;
      lines_got     <= 24'h000000;
    end else begin
      state  <= next_state;
      lval_q <= lval_s;
      if (!live | closing | lval_fall) in_line <= 1'b0;
      else if (lval_rise) in_line <= 1'b1;
      if (opening | closing) close_pending <= 1'b0;
      else if ((state == window_pkg::ST_OPEN) & close_hit) close_pending <= 1'b1;
      if (opening) begin
        line_index <= 24'h000000;
        lines_got  <= 24'h000000;
      end else if (line_end) begin
        line_index <= line_index + 24'h000001;
        if (line_wanted) lines_got <= lines_got + 24'h000001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Word window
  // ----------------------------------------------------------------------
  assign word_in_range = (word_index >= words_to_skip) &
                         ((word_index - words_to_skip) < words_to_take);
  assign word_take     = live & line_active & line_wanted & word_in_range & wv_s;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      word_index <= 24'h000000;
    end else if (opening | line_end | lval_fall) begin
      word_index <= 24'h000000;
    end else if (live & line_active & wv_s) begin
      word_index <= word_index + 24'h000001;
    end
  end

  // ----------------------------------------------------------------------
  // Volume counter
  // ----------------------------------------------------------------------
  logic        vol_clear_evt;
  logic        vol_update_evt;
  logic [23:0] next_volume;

  assign vol_clear_evt = (volume_count_clear_mode == 2'h0) ? acq_start :
                         (volume_count_clear_mode == 2'h1) ? volume_start :
                         (volume_count_clear_mode == 2'h2) ? sequence_start : opening;
  assign vol_update_evt = (volume_count_update_mode == 2'h0) ? 1'b1 :
                          (volume_count_update_mode == 2'h1) ? volume_end :
                          (volume_count_update_mode == 2'h2) ? sequence_end : closing;
  // A volume ending in the clearing cycle still counts: the set wins
  assign next_volume = (vol_clear_evt | wr_vol) ? {23'h000000, volume_end}
                                                : volume_running + {23'h000000, volume_end};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      volume_running   <= `RST_VOLUME;
      volumes_acquired <= `RST_VOLUME;
    end else begin
      volume_running <= next_volume;
      if (vol_update_evt | wr_vol) volumes_acquired <= next_volume;
    end
  end

  // ----------------------------------------------------------------------
  // Read port and outputs
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;

  assign rd_mux =
    (reg_addr == `OFS_LINE_CONTROL)    ? line_window_control :
    (reg_addr == `OFS_LINE_DIMS)       ? line_window_dimensions :
    (reg_addr == `OFS_LINE_DIMS_UPPER) ? line_window_dimensions_upper :
    (reg_addr == `OFS_WORD_DIMS)       ? word_window_dimensions :
    (reg_addr == `OFS_WORD_DIMS_UPPER) ? word_window_dimensions_upper :
    (reg_addr == `OFS_VOLUME_COUNT)    ? {volume_count_update_mode, volume_count_clear_mode,
                                          4'h0, volumes_acquired} :
                                         32'h00000000;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata        <= 32'h00000000;
      line_window_open <= 1'b0;
      word_window_open <= 1'b0;
      word_out_valid   <= 1'b0;
      word_out         <= 128'h0;
      line_done        <= 1'b0;
      frame_done       <= 1'b0;
    end else begin
      reg_rdata        <= reg_read ? rd_mux : 32'h00000000;
      line_window_open <= (next_state == window_pkg::ST_OPEN);
      word_window_open <= live & !closing & line_active & line_wanted & word_in_range;
      word_out_valid   <= word_take;
      if (word_take) word_out <= word_s;
      line_done        <= line_end & line_wanted;
      frame_done       <= closing;
    end
  end

endmodule

/* File: design/sync_bits.sv */
`timescale 1ns/10ps
module sync_bits #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,      // System clock
  input  wire logic             rst_b,    // Synchronous reset
  input  wire logic [WIDTH-1:0] async_in, // Pins from outside the clock domain
  output logic      [WIDTH-1:0] sync_out  // Same pins, two flops later
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* File: design/trigger_condition.sv */
`timescale 1ns/10ps
`include "window_defs.svh"
module trigger_condition (
  input  wire logic       clk,      // System clock
  input  wire logic       rst_b,    // Synchronous reset
  input  wire logic [5:0] sources,  // Synchronised trigger sources, bit 5 is FVAL
  input  wire logic [3:0] source,   // Source select code
  input  wire logic [3:0] cond,     // Conditioning code
  output logic            hit       // Condition met this cycle
);

  logic [5:0] prev;
  logic       level;
  logic       was;

  // Unknown source codes read as low, so they fire only under the low condition
  assign level = (source < 4'h6) ? sources[source[2:0]] : 1'b0;
  assign was   = (source < 4'h6) ? prev[source[2:0]] : 1'b0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev <= '0;
    end else begin
      prev <= sources;
    end
  end

  always_comb begin
    hit = 1'b0;
    if (source == `SRC_FVAL_FALL) begin
      hit = was & ~level;
    end else begin
      case (cond)
        window_pkg::COND_RISE:   hit = level & ~was;
        window_pkg::COND_FALL:   hit = ~level & was;
        window_pkg::COND_HIGH:   hit = level;
        window_pkg::COND_LOW:    hit = ~level;
        window_pkg::COND_EITHER: hit = level ^ was;
        default:                 hit = 1'b0;
      endcase
    end
  end

endmodule

/* File: design/window_defs.svh */
// What this block does
// - Close source code 0..4 picks trigger or encoder; code 5 is FVAL falling edge.
// - Close mode 0 closes after the programmed count of complete lines, then rearms.
// - Close mode 1 waits for close trigger, finishes current line, closes, rearms.
// - Close mode 2 closes on size or trigger, whichever happens first.
// - Open conditioning: 0 rise, 1 fall, 2 high, 3 low, 4 either edge.
// - Open source code 0..4 picks trigger, encoder A, B, divider or quad.
// - Immediate open waits only for line sync, then opens line and word windows.
// - Trigger open waits for the conditioned source, then opens the windows.
// - Line sync 0: all data after opening belongs to the current line.
// - Line sync 1: data before start of line, taken from LVAL, is dropped.
// - Low half of line dimensions gives lines acquired per frame after skipping.
// - High half of line dimensions gives lines skipped after the window opens.
// - Low byte of line dimensions upper extends the line count by 8 bits.
// - Bits 23..16 of line dimensions upper extend the line skip by 8 bits.
// - Low half of word dimensions gives 16-byte words taken per line after skip.
// - High half of word dimensions gives 16-byte words skipped in each line.
// - Low byte of word dimensions upper extends the word count by 8 bits.
// - Bits 23..16 of word dimensions upper extend the word skip by 8 bits.
// - Close conditioning: 0 rise, 1 fall, 2 high, 3 low, 4 either edge.
// - 24-bit volume counter counts volumes; any write to its register clears it.
// - Clear mode: acquisition start, volume, sequence or line window start.
// - Update mode: continuous, or end of volume, sequence or line window.
`ifndef WINDOW_DEFS_SVH
`define WINDOW_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_LINE_CONTROL      8'h00
`define OFS_LINE_DIMS         8'h04
`define OFS_LINE_DIMS_UPPER   8'h08
`define OFS_WORD_DIMS         8'h0c
`define OFS_WORD_DIMS_UPPER   8'h10
`define OFS_VOLUME_COUNT      8'h14

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define LSB_CLOSE_COND        0
`define LSB_CLOSE_SRC         4
`define LSB_CLOSE_MODE        8
`define LSB_OPEN_COND         12
`define LSB_OPEN_SRC          16
`define LSB_OPEN_MODE         20
`define LSB_LINE_SYNC         24
`define LSB_SIZE              0
`define LSB_SKIP              16
`define LSB_VOL_CLR_MODE      28
`define LSB_VOL_UPD_MODE      30
`define MASK_LINE_CONTROL     32'h0fffffff
`define MASK_DIMS_UPPER       32'h00ff00ff
`define SRC_FVAL_FALL         4'h5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_LINE_CONTROL      32'h00000000
`define RST_DIMS              32'h00000000
`define RST_VOLUME            24'h000000

`endif

/* File: design/window_pkg.sv */
package window_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_OPEN,
    ST_OPEN
  } state_t;

  typedef enum logic [3:0] {
    CLOSE_SIZE    = 4'h0,
    CLOSE_TRIGGER = 4'h1,
    CLOSE_EITHER  = 4'h2
  } close_mode_t;

  typedef enum logic [3:0] {
    COND_RISE   = 4'h0,
    COND_FALL   = 4'h1,
    COND_HIGH   = 4'h2,
    COND_LOW    = 4'h3,
    COND_EITHER = 4'h4
  } trig_cond_t;

endpackage

/* File: test/cam_model.sv */
`timescale 1ns/10ps
module cam_model (
  input  wire logic         clk,  // Clock
  output logic              fval, // Frame valid
  output logic              lval, // Line valid
  output logic              wv,   // Word strobe
  output logic      [127:0] word  // Data word
);
  logic [15:0] seq = 16'h0;
  initial begin
    fval = 1'b0;
    lval = 1'b0;
    wv   = 1'b0;
    word = '0;
  end
  // Idle data is inverted so a stale word never passes for a fresh one
  task automatic frame(input int lines, input int words);
    repeat (8) @(posedge clk);
    fval <= 1'b1;
    repeat (lines) begin
      repeat (2) @(posedge clk);
      lval <= 1'b1;
      repeat (words) begin
        @(posedge clk);
        seq = seq + 16'h1;
        wv <= 1'b1;
        word <= {8{seq}};
        @(posedge clk);
        wv <= 1'b0;
        word <= ~{8{seq}};
      end
      @(posedge clk);
      lval <= 1'b0;
    end
    repeat (2) @(posedge clk);
    fval <= 1'b0;
  endtask
endmodule

/* File: test/line_word_window_asserts.sv */
`timescale 1ns/10ps
module line_word_window_asserts (
  input wire logic         clk,              // Clock
  input wire logic         rst_b,            // Reset
  input wire logic [7:0]   reg_addr,         // Address
  input wire logic         reg_read,         // Read strobe
  input wire logic [31:0]  reg_rdata,        // Read data
  input wire logic         cam_lval,         // Line valid pin
  input wire logic         cam_word_valid,   // Word strobe pin
  input wire logic [127:0] cam_word,         // Word pin
  input wire logic         acq_enable,       // Frames remain
  input wire logic         line_window_open, // Line window
  input wire logic         word_out_valid,   // Word strobe out
  input wire logic [127:0] word_out,         // Word out
  input wire logic         line_done,        // Line end pulse
  input wire logic         frame_done        // Close pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_word_in_win;
    word_out_valid |-> line_window_open || $past(line_window_open);
  endproperty
  a_word_in_win: assert property (p_word_in_win) else $error("word outside window");
  property p_word_src;
    word_out_valid |-> $past(cam_word_valid, 3) && word_out == $past(cam_word, 3);
  endproperty
  a_word_src: assert property (p_word_src) else $error("word not from camera");
  property p_close_pulse;
    $fell(line_window_open) |-> frame_done;
  endproperty
  a_close_pulse: assert property (p_close_pulse) else $error("close without pulse");
  property p_open_enable;
    $rose(line_window_open) |-> $past(acq_enable);
  endproperty
  a_open_enable: assert property (p_open_enable) else $error("open without frames");
  property p_line_done;
    line_done |-> $past(cam_lval, 4) && !$past(cam_lval, 3);
  endproperty
  a_line_done: assert property (p_line_done) else $error("line end not at lval fall");
  property p_upper_rsvd;
    $past(reg_read) && $past(reg_addr) == 8'h08 |-> (reg_rdata & 32'hff00ff00) == 32'h0;
  endproperty
  a_upper_rsvd: assert property (p_upper_rsvd) else $error("reserved bits set");
  property p_ctrl_rsvd;
    $past(reg_read) && $past(reg_addr) == 8'h00 |-> reg_rdata[31:28] == 4'h0;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved set");
  property p_unmapped;
    $past(reg_read) && $past(reg_addr) > 8'h14 |-> reg_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
endmodule
bind line_word_window line_word_window_asserts line_word_window_asserts_inst (.clk, .rst_b,
  .reg_addr, .reg_read, .reg_rdata, .cam_lval, .cam_word_valid, .cam_word, .acq_enable,
  .line_window_open, .word_out_valid, .word_out, .line_done, .frame_done);

/* File: test/tb_line_word_window.sv */
`timescale 1ns/10ps
module tb_line_word_window;
  logic clk = 1'b0, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0, acq_enable = 1'b0;
  logic acq_start = 1'b0, volume_end = 1'b0, fval, lval, wv;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [4:0] trig = 5'h0;
  logic [127:0] word, wout;
  logic lwo, wwo, wov, ldone, fdone;
  int error_cnt = 0, total_checks = 0, lines, words, dones, sum;
  always #2 clk = ~clk;
  cam_model cam_model_inst (.clk(clk), .fval(fval), .lval(lval), .wv(wv), .word(word));
  line_word_window line_word_window_inst (.clk(clk), .rst_b(rst_b), .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata),
    .cam_fval(fval), .cam_lval(lval), .cam_word_valid(wv), .cam_word(word),
    .trig_in(trig[0]), .enc_a_in(trig[1]), .enc_b_in(trig[2]), .enc_div_in(trig[3]),
    .enc_quad_in(trig[4]), .acq_enable(acq_enable), .acq_start(acq_start),
    .volume_start(1'b0), .volume_end(volume_end), .sequence_start(1'b0),
    .sequence_end(1'b0), .line_window_open(lwo), .word_window_open(wwo),
    .word_out_valid(wov), .word_out(wout), .line_done(ldone), .frame_done(fdone));
  always @(posedge clk) begin
    lines += int'(ldone);
    dones += int'(fdone);
    if (wov === 1'b1) begin
      words += int'(wwo === 1'b1);
      sum += int'(wout[15:0]);
    end
  end
  // ----------------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) {wr_s, addr, wdata} <= {1'b1, a, v};
    @(posedge clk) wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk) {rd_s, addr} <= {1'b1, a};
    @(posedge clk) rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  // Runs one frame; expected words follow from both skips, the word size and the expected line count
  task automatic run(input logic [31:0] ctl, ld, wd, input int nl, nw, input logic [4:0] tp,
                     input int tw, el);
    int base, es, ew;
    wr(8'h00, ctl);
    wr(8'h04, ld);
    wr(8'h0c, wd);
    base = int'(cam_model_inst.seq);
    {lines, words, dones, sum, es} = '0;
    acq_enable <= 1'b1;
    fork
      cam_model_inst.frame(nl, nw);
      begin
        wait (lines == tw || tw > el);
        @(posedge clk) trig <= tp;
        repeat (4) @(posedge clk);
        trig <= 5'h0;
      end
      begin
        for (int k = 0; k < 100 && lwo !== 1'b1; k++) @(posedge clk);
        acq_enable <= 1'b0;
      end
    join
    repeat (8) @(posedge clk);
    for (int i = int'(ld[31:16]); i < int'(ld[31:16]) + el; i++)
      for (int j = int'(wd[31:16]); j < int'(wd[31:16] + wd[15:0]) && j < nw; j++) begin
        es += base + i * nw + j + 1;
        ew++;
      end
    chk("lines", lines, el);
    chk("closes", dones, int'(el > 0));
    chk("word sum", sum, es);
    chk("words", words, ew);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
    logic [31:0] rm [6] = '{32'h0fffffff, '1, 32'h00ff00ff, '1, 32'h00ff00ff, 32'h0};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd(ra[k], d);
      chk("reset value", d, 32'h0);
      wr(ra[k], '1);
      rd(ra[k], d);
      chk("read back", d, rm[k]);
      wr(ra[k], 32'h0);
    end
    wr(8'h14, '1);
    rd(8'h14, d);
    chk("volume modes", d, 32'hf0000000);
    wr(8'h14, 32'h0);
    repeat (3) begin
      @(posedge clk) volume_end <= 1'b1;
      @(posedge clk) volume_end <= 1'b0;
    end
    rd(8'h14, d);
    chk("volume count", d, 32'h3);
    @(posedge clk) acq_start <= 1'b1;
    @(posedge clk) acq_start <= 1'b0;
    rd(8'h14, d);
    chk("volume clear", d, 32'h0);
    run(32'h0, 32'h00010002, 32'h00010002, 4, 4, 5'h00, 0, 2);
    run(32'h00000100, 32'h64, 32'h3, 4, 3, 5'h01, 1, 2);
    run(32'h00000242, 32'h3, 32'h1, 4, 1, 5'h10, 1, 2);
    run(32'h00000250, 32'h64, 32'h1, 3, 1, 5'h00, 9, 3);
    run(32'h00111000, 32'h2, 32'h2, 3, 2, 5'h02, 0, 2);
    run(32'h00120000, 32'h2, 32'h2, 3, 2, 5'h00, 9, 0);
    run(32'h01000000, 32'h2, 32'h2, 3, 2, 5'h00, 9, 2);
    tally_and_finish;
  end
endmodule
